/* inc/csp_pkg.sv */
package csp_pkg;

   // Clock and timing.
   localparam int unsigned CLK_FREQ_MHZ      = 50;
   localparam int unsigned CLK_PERIOD_NS     = 20;
   localparam int unsigned DELAY_STEP_NS     = 1;
   localparam int unsigned DELAY_STEP_CYCLES_RAW = (DELAY_STEP_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned DELAY_STEP_CYCLES = (DELAY_STEP_CYCLES_RAW < 1) ? 1 : DELAY_STEP_CYCLES_RAW;
   localparam int unsigned DELAY_MAX_CODE    = 7;

   // Delay register layout, shared by both delay registers.
   localparam int unsigned DLY_REG_W    = 9;
   localparam int unsigned DLY_FIELD_W  = 3;
   localparam int unsigned DLY_LO_POS   = 0;
   localparam int unsigned DLY_MID_POS  = 3;
   localparam int unsigned DLY_HI_POS   = 6;
   localparam logic [8:0]  DLY_RESET    = 9'h000;

   // Polarity register layout; a cleared bit means active low.
   localparam int unsigned POL_W          = 6;
   localparam int unsigned POL_BLACK_POS  = 0;
   localparam int unsigned POL_VIDEO_POS  = 1;
   localparam int unsigned POL_CONV_POS   = 2;
   localparam int unsigned POL_CLAMP_POS  = 3;
   localparam int unsigned POL_CAL_POS    = 4;
   localparam int unsigned POL_SPARE_POS  = 5;
   localparam logic [5:0]  POL_RESET      = 6'h00;

   // Number of synchronised timing pin inputs.
   localparam int unsigned PIN_W         = 5;

   // One-shot line mode clamp length in pixels.
   localparam int unsigned SINGLE_WINDOW_LINE_MODE_CLAMP_PIXELS = 4;
   localparam int unsigned PIX_CNT_W            = 3;

endpackage

/* hdl/csp_sync2.sv */
`timescale 1ns/1ns
module csp_sync2
#(
   parameter int unsigned WIDTH = 1
)
(
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

/* hdl/csp_edge_delay.sv */
`timescale 1ns/1ns
module csp_edge_delay
#(
   parameter int unsigned STEP = 1
)
(
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       level_in,
   input  wire logic [2:0] lead_code,
   input  wire logic [2:0] trail_code,
   output logic            level_out
);

   localparam int unsigned DEPTH = 7 * STEP + 1;

   logic [DEPTH-1:0] hist_reg;
   logic [DEPTH-1:0] hist_next;
   logic             lead_tap;
   logic             trail_tap;
   logic             level_next;

   // Tap index grows by one step per code, so the delay is monotonic.
   assign hist_next  = {hist_reg[DEPTH-2:0], level_in};
   assign lead_tap   = hist_reg[32'(lead_code) * STEP];
   assign trail_tap  = hist_reg[32'(trail_code) * STEP];
   // Union or overlap of the taps; a pulse narrower than the code gap may split or vanish.
   assign level_next = (lead_code <= trail_code) ? (lead_tap | trail_tap) : (lead_tap & trail_tap);

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hist_reg  <= '0;
         level_out <= 1'b0;
      end
      else
      begin
         hist_reg  <= hist_next;
         level_out <= level_next;
      end
   end

endmodule

/* hdl/csp_phase_gen.sv */
// Overview of operation
// - Option clear: video switch after delayed black end.
// - Option set: video switch follows video pulse only.
// - Reject disabled: reset reject switch stays closed.
// - Reject enabled: open at video end, close at black.
// - Two delay registers, three 3-bit fields each.
// - Delays follow polarity-defined leading and trailing edges.
// - First low field delays black leading edge.
// - First middle field delays black trailing edge.
// - Second low field delays video switch leading edge.
// - Second middle field delays video trailing edge.
// - Second high field adds after black trailing delay.
// - First high field delays converter clock both edges.
// - Two-signal mode: clamp restores, window marks black.
// - Isolate bit disconnects sampler during vertical shift.
// - Order clear: shift from window end to clamp.
// - Order set: shift from clamp end to window.
// - Line order bit also goes to calibration.
// - One-shot: clamp first four pixels, rest calibrate.
// - One-shot isolation period comes from clamp input.
// - Six polarity bits, all reset to active low.
`timescale 1ns/1ns
module csp_phase_gen
(
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       black_sample_pulse,
   input  wire logic       video_sample_pulse,
   input  wire logic       converter_clock,
   input  wire logic       clamp_pin,
   input  wire logic       cal_window_pin,
   input  wire logic       delay_first_wr,
   input  wire logic       delay_second_wr,
   input  wire logic       polarity_wr,
   input  wire logic [8:0] delay_wdata,
   input  wire logic [5:0] polarity_wdata,
   input  wire logic       video_switch_option,
   input  wire logic       reset_pulse_reject_enable,
   input  wire logic       vshift_isolate,
   input  wire logic       line_order_select,
   input  wire logic       single_window_line_mode,
   output logic [8:0]      sample_edge_delay_first,
   output logic [8:0]      sample_edge_delay_second,
   output logic [5:0]      polarity_bits,
   output logic            black_switch_on,
   output logic            video_switch_on,
   output logic            reset_reject_switch_on,
   output logic            converter_clock_delayed,
   output logic            clamp_switch_on,
   output logic            calib_black_window,
   output logic            input_isolate,
   output logic            calib_line_order
);

   localparam int unsigned STEP = csp_pkg::DELAY_STEP_CYCLES;
   localparam int unsigned HI_DEPTH = 7 * STEP + 1;

   // Register file.
   logic [8:0] dly_first_reg;
   logic [8:0] dly_first_next;
   logic [8:0] dly_second_reg;
   logic [8:0] dly_second_next;
   logic [5:0] pol_reg;
   logic [5:0] pol_next;

   assign dly_first_next  = delay_first_wr ? delay_wdata : dly_first_reg;
   assign dly_second_next = delay_second_wr ? delay_wdata : dly_second_reg;
   assign pol_next        = polarity_wr ? polarity_wdata : pol_reg;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dly_first_reg  <= csp_pkg::DLY_RESET;
         dly_second_reg <= csp_pkg::DLY_RESET;
         pol_reg        <= csp_pkg::POL_RESET;
      end
      else
      begin
         dly_first_reg  <= dly_first_next;
         dly_second_reg <= dly_second_next;
         pol_reg        <= pol_next;
      end
   end

   // Delay fields.
   logic [2:0] a_lo;
   logic [2:0] a_mid;
   logic [2:0] a_hi;
   logic [2:0] b_lo;
   logic [2:0] b_mid;
   logic [2:0] b_hi;

   assign a_lo  = dly_first_reg[csp_pkg::DLY_LO_POS +: csp_pkg::DLY_FIELD_W];
   assign a_mid = dly_first_reg[csp_pkg::DLY_MID_POS +: csp_pkg::DLY_FIELD_W];
   assign a_hi  = dly_first_reg[csp_pkg::DLY_HI_POS +: csp_pkg::DLY_FIELD_W];
   assign b_lo  = dly_second_reg[csp_pkg::DLY_LO_POS +: csp_pkg::DLY_FIELD_W];
   assign b_mid = dly_second_reg[csp_pkg::DLY_MID_POS +: csp_pkg::DLY_FIELD_W];
   assign b_hi  = dly_second_reg[csp_pkg::DLY_HI_POS +: csp_pkg::DLY_FIELD_W];

   // Pin synchronisation; all timing pins come from another clock domain.
   logic [4:0] pins_raw;
   logic [4:0] pins_sync;

   assign pins_raw = {cal_window_pin, clamp_pin, converter_clock, video_sample_pulse, black_sample_pulse};

   csp_sync2
   #(
      .WIDTH (csp_pkg::PIN_W)
   )
   u_sync
   (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   // Polarity selection: a cleared bit means the pin is active low.
   logic blk_act;
   logic vid_act;
   logic conv_act;
   logic clamp_act;
   logic cal_act;

   assign blk_act   = ~(pins_sync[0] ^ pol_reg[csp_pkg::POL_BLACK_POS]);
   assign vid_act   = ~(pins_sync[1] ^ pol_reg[csp_pkg::POL_VIDEO_POS]);
   assign conv_act  = ~(pins_sync[2] ^ pol_reg[csp_pkg::POL_CONV_POS]);
   assign clamp_act = ~(pins_sync[3] ^ pol_reg[csp_pkg::POL_CLAMP_POS]);
   assign cal_act   = ~(pins_sync[4] ^ pol_reg[csp_pkg::POL_CAL_POS]);

   // Previous values for edge detection on the polarity-corrected levels.
   logic blk_prev_reg;
   logic vid_prev_reg;
   logic clamp_prev_reg;
   logic cal_prev_reg;
   logic blk_del_prev_reg;

   // Black switch: leading edge by first low field, trailing by first middle field.
   logic blk_del;

   csp_edge_delay
   #(
      .STEP (STEP)
   )
   u_black_dly
   (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .level_in   (blk_act),
      .lead_code  (a_lo),
      .trail_code (a_mid),
      .level_out  (blk_del)
   );

   // Converter clock: same delay on both edges.
   logic conv_del;

   csp_edge_delay
   #(
      .STEP (STEP)
   )
   u_conv_dly
   (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .level_in   (conv_act),
      .lead_code  (a_hi),
      .trail_code (a_hi),
      .level_out  (conv_del)
   );

   // Video switch source. The extra delay counts from the already delayed black
   // trailing edge, so it stacks on top of the first middle field.
   logic                blk_end_evt;
   logic                vid_end_evt;
   logic                vid_start_evt;
   logic                blk_start_evt;
   logic [HI_DEPTH-1:0] blk_end_hist_reg;
   logic [HI_DEPTH-1:0] blk_end_hist_next;
   logic                vid_open_evt;
   logic                vid_src_reg;
   logic                vid_src_next;
   logic                vid_raw;

   assign blk_end_evt       = blk_del_prev_reg & ~blk_del;
   assign blk_start_evt     = blk_act & ~blk_prev_reg;
   assign vid_end_evt       = vid_prev_reg & ~vid_act;
   assign vid_start_evt     = vid_act & ~vid_prev_reg;
   assign blk_end_hist_next = {blk_end_hist_reg[HI_DEPTH-2:0], blk_end_evt};
   assign vid_open_evt      = blk_end_hist_next[32'(b_hi) * STEP];
   assign vid_src_next      = vid_open_evt ? 1'b1 : (vid_end_evt ? 1'b0 : vid_src_reg);
   assign vid_raw           = video_switch_option ? vid_act : vid_src_reg;

   logic vid_del;

   csp_edge_delay
   #(
      .STEP (STEP)
   )
   u_video_dly
   (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .level_in   (vid_raw),
      .lead_code  (b_lo),
      .trail_code (b_mid),
      .level_out  (vid_del)
   );

   // Reset reject switch: opened after the video sample, closed at the next black sample.
   logic rr_closed_reg;
   logic rr_closed_next;

   assign rr_closed_next = !reset_pulse_reject_enable ? 1'b1 :
                           blk_start_evt ? 1'b1 :
                           vid_end_evt ? 1'b0 : rr_closed_reg;

   // Line rate logic.
   logic                 cal_start_evt;
   logic                 cal_end_evt;
   logic                 clamp_start_evt;
   logic                 clamp_end_evt;
   logic [2:0]           pix_cnt_reg;
   logic [2:0]           pix_cnt_next;
   logic                 pix_tick;
   logic                 early_pixels;
   logic                 clamp_next;
   logic                 calib_next;
   logic                 vshift_reg;
   logic                 vshift_next;
   logic                 vshift_level;
   logic                 isolate_next;

   assign cal_start_evt   = cal_act & ~cal_prev_reg;
   assign cal_end_evt     = cal_prev_reg & ~cal_act;
   assign clamp_start_evt = clamp_act & ~clamp_prev_reg;
   assign clamp_end_evt   = clamp_prev_reg & ~clamp_act;

   // Pixels are counted on completed video samples inside the window.
   assign pix_tick     = cal_act & vid_end_evt & (pix_cnt_reg != 3'(csp_pkg::SINGLE_WINDOW_LINE_MODE_CLAMP_PIXELS));
   assign pix_cnt_next = cal_start_evt ? 3'h0 : (pix_tick ? pix_cnt_reg + 3'h1 : pix_cnt_reg);
   assign early_pixels = cal_act & (pix_cnt_reg < 3'(csp_pkg::SINGLE_WINDOW_LINE_MODE_CLAMP_PIXELS));

   assign clamp_next = single_window_line_mode ? early_pixels : clamp_act;
   assign calib_next = single_window_line_mode ? (cal_act & ~early_pixels) : cal_act;

   // Vertical shift interval tracking for the two-signal mode.
   assign vshift_next = line_order_select ?
                        (clamp_end_evt ? 1'b1 : (cal_start_evt ? 1'b0 : vshift_reg)) :
                        (cal_end_evt ? 1'b1 : (clamp_start_evt ? 1'b0 : vshift_reg));
   assign vshift_level = single_window_line_mode ? clamp_act : vshift_reg;
   assign isolate_next = vshift_isolate & vshift_level;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         blk_prev_reg     <= 1'b1;
         vid_prev_reg     <= 1'b1;
         clamp_prev_reg   <= 1'b1;
         cal_prev_reg     <= 1'b1;
         blk_del_prev_reg <= 1'b0;
         blk_end_hist_reg <= '0;
         vid_src_reg      <= 1'b0;
         rr_closed_reg    <= 1'b1;
         pix_cnt_reg      <= 3'h0;
         vshift_reg       <= 1'b0;
      end
      else
      begin
         blk_prev_reg     <= blk_act;
         vid_prev_reg     <= vid_act;
         clamp_prev_reg   <= clamp_act;
         cal_prev_reg     <= cal_act;
         blk_del_prev_reg <= blk_del;
         blk_end_hist_reg <= blk_end_hist_next;
         vid_src_reg      <= vid_src_next;
         rr_closed_reg    <= rr_closed_next;
         pix_cnt_reg      <= pix_cnt_next;
         vshift_reg       <= vshift_next;
      end
   end

   // Output stage; every output leaves from a flip-flop.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sample_edge_delay_first  <= csp_pkg::DLY_RESET;
         sample_edge_delay_second <= csp_pkg::DLY_RESET;
         polarity_bits            <= csp_pkg::POL_RESET;
         black_switch_on          <= 1'b0;
         video_switch_on          <= 1'b0;
         reset_reject_switch_on   <= 1'b1;
         converter_clock_delayed  <= 1'b0;
         clamp_switch_on          <= 1'b0;
         calib_black_window       <= 1'b0;
         input_isolate            <= 1'b0;
         calib_line_order         <= 1'b0;
      end
      else
      begin
         sample_edge_delay_first  <= dly_first_reg;
         sample_edge_delay_second <= dly_second_reg;
         polarity_bits            <= pol_reg;
         black_switch_on          <= blk_del;
         video_switch_on          <= vid_del;
         reset_reject_switch_on   <= rr_closed_reg;
         converter_clock_delayed  <= conv_del;
         clamp_switch_on          <= clamp_next;
         calib_black_window       <= calib_next;
         input_isolate            <= isolate_next;
         calib_line_order         <= line_order_select;
      end
   end

   // The source keeps clamp and window apart in the two-signal mode; if both
   // arrive together they are passed through unchanged.
   // The window is expected to cover the longest black run of a line.

endmodule

/* tb/csp_phase_gen_asserts.sv */
`timescale 1ns/1ns
module csp_phase_gen_asserts
(
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       black_sample_pulse,
   input wire logic       video_sample_pulse,
   input wire logic       delay_first_wr,
   input wire logic       delay_second_wr,
   input wire logic [8:0] delay_wdata,
   input wire logic       reset_pulse_reject_enable,
   input wire logic       vshift_isolate,
   input wire logic       single_window_line_mode,
   input wire logic [8:0] sample_edge_delay_first,
   input wire logic [8:0] sample_edge_delay_second,
   input wire logic [5:0] polarity_bits,
   input wire logic       black_switch_on,
   input wire logic       reset_reject_switch_on,
   input wire logic       clamp_switch_on,
   input wire logic       calib_black_window,
   input wire logic       input_isolate
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_rr_closed;
      (!reset_pulse_reject_enable)[*5] |-> reset_reject_switch_on;
   endproperty
   a_rr_closed: assert property (p_rr_closed) else $error("Reject switch open.");
   property p_rr_open;
      (reset_pulse_reject_enable && !polarity_bits[1] && $rose(video_sample_pulse))
         ##0 reset_pulse_reject_enable[*6] |-> !reset_reject_switch_on;
   endproperty
   a_rr_open: assert property (p_rr_open) else $error("Reject switch closed.");
   property p_reg_first;
      delay_first_wr |-> ##2 (sample_edge_delay_first == $past(delay_wdata, 2));
   endproperty
   a_reg_first: assert property (p_reg_first) else $error("First delay readback.");
   property p_reg_second;
      delay_second_wr |-> ##2 (sample_edge_delay_second == $past(delay_wdata, 2));
   endproperty
   a_reg_second: assert property (p_reg_second) else $error("Second delay readback.");
   property p_pol_reset;
      $rose(reset_n) |-> (polarity_bits == 6'h00) && (sample_edge_delay_second == 9'h000);
   endproperty
   a_pol_reset: assert property (p_pol_reset) else $error("Reset values.");
   property p_black_lead;
      ($fell(black_sample_pulse) && !polarity_bits[0] && sample_edge_delay_first[2:0] == 3'h0)
         |-> ##5 black_switch_on;
   endproperty
   a_black_lead: assert property (p_black_lead) else $error("Black switch late.");
   property p_iso_off;
      (!vshift_isolate)[*6] |-> !input_isolate;
   endproperty
   a_iso_off: assert property (p_iso_off) else $error("Isolated while disabled.");
   property p_osh_excl;
      single_window_line_mode[*8] |-> !(clamp_switch_on && calib_black_window);
   endproperty
   a_osh_excl: assert property (p_osh_excl) else $error("Clamp and window overlap.");
   c_wr: cover property (delay_second_wr);
   c_rr: cover property (reset_pulse_reject_enable && !reset_reject_switch_on);
   c_osh: cover property (single_window_line_mode && clamp_switch_on);
   c_iso: cover property (input_isolate);
endmodule
bind csp_phase_gen csp_phase_gen_asserts u_chk
(
   .clk_sys, .reset_n, .black_sample_pulse, .video_sample_pulse, .delay_first_wr,
   .delay_second_wr, .delay_wdata, .reset_pulse_reject_enable, .vshift_isolate,
   .single_window_line_mode, .sample_edge_delay_first, .sample_edge_delay_second,
   .polarity_bits, .black_switch_on, .reset_reject_switch_on, .clamp_switch_on,
   .calib_black_window, .input_isolate
);

/* tb/csp_ccd_gen.sv */
`timescale 1ns/1ns
module csp_ccd_gen
(
   input  wire logic [5:0] pol,
   input  wire logic       clk_sys,
   output logic            black_sample_pulse,
   output logic            video_sample_pulse,
   output logic            converter_clock,
   output logic            clamp_pin,
   output logic            cal_window_pin
);
   int cyc = 0;
   always @(negedge clk_sys)
   begin
      cyc <= cyc + 1;
   end
   // Pulses are eight cycles wide so that no delay code can merge them.
   assign black_sample_pulse = ((cyc % 32) < 8) ^ ~pol[0];
   assign video_sample_pulse = ((cyc % 32) >= 16 && (cyc % 32) < 24) ^ ~pol[1];
   assign converter_clock = ((cyc % 16) < 8) ^ ~pol[2];
   assign clamp_pin = (((cyc / 32) % 12) < 2) ^ ~pol[3];
   assign cal_window_pin = (((cyc / 32) % 12) >= 4 && ((cyc / 32) % 12) < 10) ^ ~pol[4];
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   localparam int RUN_CYC = 20000;
   logic       clk_sys = 0;
   logic       reset_n = 0;
   logic       delay_first_wr = 0;
   logic       delay_second_wr = 0;
   logic       polarity_wr = 0;
   logic [8:0] delay_wdata = 9'h000;
   logic [5:0] polarity_wdata = 6'h00;
   logic       video_switch_option = 0;
   logic       reset_pulse_reject_enable = 0;
   logic       vshift_isolate = 0;
   logic       line_order_select = 0;
   logic       single_window_line_mode = 0;
   logic [5:0] pol_g = 6'h00;
   logic [5:0] pol_m = 6'h00;
   logic [8:0] da = 9'h000;
   logic [8:0] db = 9'h000;
   logic [4:0] h [0:15];
   logic       rr_m = 1;
   logic       vs_m = 0;
   logic       vid_q = 0;
   logic       chk_en = 0;
   logic       rr_en_q = 0;
   int         n_cl, n_ca, n_vr;
   int         err_total = 0;
   int         n_compared = 0;
   logic       black_sample_pulse, video_sample_pulse, converter_clock, clamp_pin, cal_window_pin;
   logic [8:0] sample_edge_delay_first, sample_edge_delay_second;
   logic [5:0] polarity_bits;
   logic       black_switch_on, video_switch_on, reset_reject_switch_on, converter_clock_delayed;
   logic       clamp_switch_on, calib_black_window, input_isolate, calib_line_order;
   always #10 clk_sys = ~clk_sys;
   csp_ccd_gen u_csp_ccd_gen
   (
      .pol(pol_g), .clk_sys, .black_sample_pulse, .video_sample_pulse, .converter_clock,
      .clamp_pin, .cal_window_pin
   );
   csp_phase_gen u_csp_phase_gen
   (
      .clk_sys, .reset_n, .black_sample_pulse, .video_sample_pulse, .converter_clock, .clamp_pin,
      .cal_window_pin, .delay_first_wr, .delay_second_wr, .polarity_wr, .delay_wdata, .polarity_wdata,
      .video_switch_option, .reset_pulse_reject_enable, .vshift_isolate, .line_order_select,
      .single_window_line_mode, .sample_edge_delay_first, .sample_edge_delay_second, .polarity_bits,
      .black_switch_on, .video_switch_on, .reset_reject_switch_on, .converter_clock_delayed,
      .clamp_switch_on, .calib_black_window, .input_isolate, .calib_line_order
   );
   task automatic chk(input logic [8:0] s, input logic [8:0] e);
      n_compared++;
      if (s !== e)
      begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] s, input logic [8:0] d);
      @(negedge clk_sys);
      {polarity_wr, delay_second_wr, delay_first_wr} = s;
      delay_wdata = d;
      polarity_wdata = d[5:0];
      @(negedge clk_sys);
      {polarity_wr, delay_second_wr, delay_first_wr} = 3'h0;
   endtask
   // Lead L and trail T on a wide pulse: union of both shifts if L <= T, else their overlap.
   function automatic logic dly(int k, int l, int t);
      return (l <= t) ? (h[4 + l][k] | h[4 + t][k]) : (h[4 + l][k] & h[4 + t][k]);
   endfunction
   always @(posedge clk_sys)
   begin
      #1;
      for (int k = 15; k > 0; k--) h[k] = h[k - 1];
      h[0] = {cal_window_pin, clamp_pin, converter_clock, video_sample_pulse, black_sample_pulse} ^ ~pol_m[4:0];
      if (h[3][0] & !h[4][0]) rr_m = 1;
      if (!h[3][1] & h[4][1]) rr_m = 0;
      if (line_order_select ? (h[4][3] & !h[3][3]) : (h[4][4] & !h[3][4])) vs_m = 1;
      if (line_order_select ? (h[3][4] & !h[4][4]) : (h[3][3] & !h[4][3])) vs_m = 0;
      if (chk_en)
      begin
         chk(black_switch_on, dly(0, da[2:0], da[5:3]));
         chk(converter_clock_delayed, dly(2, da[8:6], da[8:6]));
         chk(reset_reject_switch_on, !reset_pulse_reject_enable | rr_m);
         chk(input_isolate, vshift_isolate & (single_window_line_mode ? h[2][3] : vs_m));
         chk(calib_line_order, line_order_select);
         if (video_switch_option) chk(video_switch_on, dly(1, db[2:0], db[5:3]));
         if (!single_window_line_mode) chk({clamp_switch_on, calib_black_window}, {h[2][3], h[2][4]});
         n_cl += clamp_switch_on;
         n_ca += calib_black_window;
         n_vr += video_switch_on & !vid_q;
      end
      vid_q = video_switch_on;
   end
   initial
   begin
      void'($urandom(43546));
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      reset_n = 1;
      repeat (3) @(negedge clk_sys);
      chk(polarity_bits, 6'h00);
      chk(sample_edge_delay_first, 9'h000);
      chk(reset_reject_switch_on, 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         chk_en = 0;
         reset_pulse_reject_enable = 0;
         {video_switch_option, rr_en_q, vshift_isolate, line_order_select} = 4'($urandom);
         single_window_line_mode = (i >= 6);
         da = 9'($urandom);
         db = 9'($urandom);
         pol_m = 6'($urandom);
         // Short opt-clear chains keep the video switch start ahead of the video end.
         if (!video_switch_option) {da[5], db[8:7]} = 3'h0;
         if (i == 0) {da[2:0], pol_m[1:0], rr_en_q} = 6'h01;
         wr(3'h1, da);
         wr(3'h2, db);
         wr(3'h4, {3'h0, pol_m});
         repeat (2) @(negedge clk_sys);
         chk(sample_edge_delay_first, da);
         chk(sample_edge_delay_second, db);
         chk(polarity_bits, pol_m);
         // Flip pin polarity while black and video pulses are idle, so no false sample edge appears.
         while ((u_csp_ccd_gen.cyc % 32) != 23) @(negedge clk_sys);
         pol_g = pol_m;
         reset_pulse_reject_enable = rr_en_q;
         repeat (400) @(negedge clk_sys);
         {n_cl, n_ca, n_vr} = 96'h0;
         chk_en = 1;
         repeat (384) @(negedge clk_sys);
         chk_en = 0;
         if (!video_switch_option) chk(9'(n_vr), 9'h00C);
         if (single_window_line_mode)
         begin
            chk(9'(n_cl + n_ca), 9'h0C0);
            chk(9'(n_cl > 117 && n_cl < 123), 9'h001);
         end
      end
      results();
   end
   initial
   begin
      #(RUN_CYC * 20);
      err_total++;
      results();
   end
endmodule
